/* File: src/panel_pkg.sv */
// constants and types shared by the front-panel status/indicator block
// assumes a 20 MHz main clock and a 1 ms prescaled timebase
package panel_pkg;
   localparam int CLK_NS        = 50;
   localparam int TICK_NS       = 1000000;
   localparam int TICK_CYC      = TICK_NS / CLK_NS;
   localparam int FLASH_MS      = 250;
   localparam int FLICKER_MS    = 50;
   localparam int FAULT_FLASH_S = 60;
   localparam int WARMUP_S      = 120;
   localparam int FAULT_TICKS   = FAULT_FLASH_S * 1000;
   localparam int WARMUP_TICKS  = WARMUP_S * 1000;
   // register offsets (byte addresses)
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_ERRS   = 4'h8;
   // control field positions
   localparam int CTRL_START = 0;
   localparam int CTRL_CLEAR = 1;
   localparam int CTRL_ABORT = 2;
   localparam int CTRL_BTM   = 3;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_EXER   = 3'h2;
   localparam logic [2:0] CLASS_NORM_MAX = 3'h2;
   // exerciser step codes
   localparam logic [3:0] T_END    = 4'h0;
   localparam logic [3:0] T_SELF   = 4'h1;
   localparam logic [3:0] T_FMT_SD = 4'h2;
   localparam logic [3:0] T_FSCAN  = 4'h3;
   localparam logic [3:0] T_FBFLY  = 4'h4;
   localparam logic [3:0] T_FWR    = 4'h5;
   localparam logic [3:0] T_SET_DD = 4'h6;
   localparam logic [3:0] T_SET_SD = 4'h7;
   localparam logic [3:0] T_WSCAN  = 4'h8;
   localparam logic [3:0] T_WBFLY  = 4'h9;
   localparam logic [3:0] T_WWR    = 4'ha;
   localparam logic DRV_FLOPPY = 1'b0;
   localparam logic DRV_FIXED  = 1'b1;
   typedef struct packed {
      logic       valid;
      logic       drive;
      logic [7:0] code;
   } err_evt_t;
   typedef struct packed {
      logic valid;
      logic drive;
   } err_clr_t;
   typedef struct packed {
      logic flp_activity;
      logic flp_door_lock;
      logic fix_ready;
      logic flp_wp;
      logic fix_wp;
      logic fault;
      logic flp_err;
      logic fix_err;
   } leds_t;
   typedef enum logic [1:0] {DG_IDLE, DG_ISSUE, DG_WAIT, DG_DONE} diag_st_t;
endpackage

/* File: src/panel_status_indicator_ctrl.sv */
// front-panel indicators, two-digit error display and exerciser sequencer
// pins arrive asynchronously; error, access and test-done inputs are on mclk
//
// Summary of operation
// R01: floppy activity lit and door locked (if fitted) while head loaded.
// R02: after power-up, flash ready and write protect fixed disk two minutes.
// R03: after warm-up, ready steady only when bad track map read fine.
// R04: each fixed-disk read or write access flickers the ready indicator.
// R05: drive fault turns ready off until fault clears.
// R06: floppy protect lit by panel switch or protected diskette.
// R07: fixed protect lit while panel switch protects fixed disk.
// R08: error flashes fault one minute, then steady until cleared.
// R09: new error restarts the one-minute fault flash.
// R10: bus initialize turns fault indicator off at once.
// R11: error indicator of displayed error's drive flashes.
// R12: display flashes latest error code, shows 00 with no error.
// R13: bus initialize clears every recorded error.
// R14: during a test show test code, 00 when done, error when failed.
// R15: both drives in error: latest flashes, other drive indicator steady.
// R16: clearing latest error moves display to other drive's error.
// R17: class 0 runs full floppy exerciser list incl. density steps.
// R18: class 1 runs class 0 list without single-density format.
// R19: class 2 runs fixed disk self-test, scan, butterfly, write/read.
// R20: class 3 runs floppy general exerciser with format, then fixed.
// R21: classes 4 and 5 single pass; 4 formats floppy, 5 does not.
// R22: class 6 floppy without format, fixed without write/read.
// R23: bus initialize out of normal mode aborts, zeroes mode/class, homes.
// R24: bus initialize in normal mode zeroes an out-of-range class.
// R25: all timing from a prescaled timebase with parameter periods.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module panel_status_indicator_ctrl
   import panel_pkg::*;
#(
   parameter int TICK_CYCLES   = TICK_CYC,
   parameter int FLASH_TICKS   = FLASH_MS,
   parameter int FLICKER_TICKS = FLICKER_MS,
   parameter int FAULT_TKS     = FAULT_TICKS,
   parameter int WARMUP_TKS    = WARMUP_TICKS
) (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              head_loaded,
   input  wire logic              lock_fitted,
   input  wire logic              flp_wp_switch,
   input  wire logic              flp_disk_wp,
   input  wire logic              fix_wp_switch,
   input  wire logic              drive_fault,
   input  wire logic              bus_init,
   input  wire logic              execute_btn,
   input  wire logic [2:0]        mode_sw,
   input  wire logic [2:0]        class_sw,
   input  wire logic              fix_access,
   input  wire panel_pkg::err_evt_t err_evt,
   input  wire panel_pkg::err_clr_t err_clr,
   input  wire logic              test_done,
   input  wire logic              test_err,
   input  wire logic [3:0]        addr,
   input  wire logic [7:0]        wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic [7:0]             rdata,
   output panel_pkg::leds_t       leds,
   output logic [7:0]             disp_code,
   output logic                   disp_blank,
   output logic                   fix_wp_force,
   output logic                   home_drives,
   output logic                   test_req,
   output logic [3:0]             test_id
);
   localparam int NSYNC = 14;
   initial begin
      if (TICK_CYCLES < 2 || FLASH_TICKS < 1 || FLICKER_TICKS < 1 ||
          FAULT_TKS < 1 || WARMUP_TKS < 1 || WARMUP_TKS >= (1 << 20) ||
          FAULT_TKS >= (1 << 20) || FLASH_TICKS >= 65536 ||
          FLICKER_TICKS >= 65536 || TICK_CYCLES >= 65536)
         $error("panel_status_indicator_ctrl: unsupported timing parameter");
   end
   // two-stage synchronisers for every pin input, switches included
   logic [NSYNC-1:0] s1_q;
   logic [NSYNC-1:0] s2_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= {head_loaded, lock_fitted, flp_wp_switch, flp_disk_wp, fix_wp_switch,
                  drive_fault, bus_init, execute_btn, mode_sw, class_sw};
         s2_q <= s1_q;
      end
   end
   logic       head_s, lock_s, fwps_s, fdwp_s, xwps_s, fault_s, init_s, exec_s;
   logic [2:0] msw_s, csw_s;
   assign {head_s, lock_s, fwps_s, fdwp_s, xwps_s, fault_s, init_s, exec_s, msw_s, csw_s}
          = s2_q;
   genvar g;
   logic init_d1_q, exec_d1_q;
   logic init_p, exec_p;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         {init_d1_q, exec_d1_q} <= 2'b00;
      else
         {init_d1_q, exec_d1_q} <= {init_s, exec_s};
   end
   assign init_p = init_s & ~init_d1_q;
   assign exec_p = exec_s & ~exec_d1_q;
   // R25: prescaled timebase
   logic [15:0] pre_q;
   logic        tick;
   assign tick = (pre_q == 16'(TICK_CYCLES - 1));
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         pre_q <= 16'h0000;
      else
         pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
   end
   // R25: flash cadence
   logic [15:0] fl_cnt_q;
   logic        flash_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         fl_cnt_q <= 16'h0000;
         flash_q  <= 1'b0;
      end else if (tick) begin
         fl_cnt_q <= (fl_cnt_q == 16'(FLASH_TICKS - 1)) ? 16'h0000 : fl_cnt_q + 16'h0001;
         flash_q  <= flash_q ^ (fl_cnt_q == 16'(FLASH_TICKS - 1));
      end
   end
   // R02: warm-up window after power-up
   logic [19:0] warm_q;
   logic        warm_done;
   assign warm_done = (warm_q == 20'(WARMUP_TKS));
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         warm_q <= 20'h00000;
      else if (tick && !warm_done)
         warm_q <= warm_q + 20'h00001;
   end
   // R04: flicker stretch after an access
   logic [15:0] flk_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         flk_q <= 16'h0000;
      else if (fix_access)
         flk_q <= 16'(FLICKER_TICKS);
      else if (tick && flk_q != 16'h0000)
         flk_q <= flk_q - 16'h0001;
   end

   // control register
   logic [7:0] ctrl_q;
   logic       wr_ctrl;
   logic       sw_start, sw_clear, sw_abort, btm_ok;
   assign wr_ctrl  = wr && (addr == REG_CTRL);
   assign sw_start = wr_ctrl && wdata[CTRL_START];
   assign sw_clear = wr_ctrl && wdata[CTRL_CLEAR];
   assign sw_abort = wr_ctrl && wdata[CTRL_ABORT];
   assign btm_ok   = ctrl_q[CTRL_BTM];
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         ctrl_q <= CTRL_RST;
      else if (wr_ctrl)
         ctrl_q <= {4'h0, wdata[CTRL_BTM], 3'h0};
   end

   // error record per drive; a new error beats a clear in the same cycle
   logic [1:0] ev_v_q;
   logic [7:0] code_q [2];
   logic       recent_q;
   logic       clr_all;
   assign clr_all = init_p | sw_clear;
   generate
      for (g = 0; g < 2; g++) begin : g_err
         logic set_g, clr_g;
         assign set_g = err_evt.valid && (err_evt.drive == 1'(g));
         assign clr_g = clr_all ||
                        (err_clr.valid && (err_clr.drive == 1'(g)));
         always_ff @(posedge mclk or negedge rst_n) begin
            if (!rst_n) begin
               ev_v_q[g] <= 1'b0;
               code_q[g] <= CODE_NONE;
            end else if (set_g) begin
               ev_v_q[g] <= 1'b1;
               code_q[g] <= err_evt.code;
            // R13: init clears all
            end else if (clr_g) begin
               ev_v_q[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // R16: latest error falls back to the other drive
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         recent_q <= DRV_FLOPPY;
      else if (err_evt.valid)
         recent_q <= err_evt.drive;
      else if (err_clr.valid && err_clr.drive == recent_q &&
               ev_v_q[~recent_q])
         recent_q <= ~recent_q;
   end

   // R08: fault flash period
   logic [19:0] flt_q;
   logic        fault_on_q;
   logic        any_err;
   assign any_err = |ev_v_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         flt_q      <= 20'h00000;
         fault_on_q <= 1'b0;
      // R09: restart on a new error
      end else if (err_evt.valid) begin
         flt_q      <= 20'h00000;
         fault_on_q <= 1'b1;
      // R10: init extinguishes
      end else if (init_p || !any_err) begin
         fault_on_q <= 1'b0;
      end else if (tick && flt_q != 20'(FAULT_TKS)) begin
         flt_q <= flt_q + 20'h00001;
      end
   end
   // mode and class latched from the panel on execute
   logic [2:0] mode_q, class_q;
   logic       start_req;
   diag_st_t   dg_q;
   logic [3:0] idx_q;
   logic [3:0] step;
   logic       home_q;
   assign start_req = exec_p | sw_start;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q  <= MODE_NORMAL;
         class_q <= 3'h0;
         home_q  <= 1'b0;
      end else begin
         // R23: abort, zero and home
         home_q <= init_p && mode_q != MODE_NORMAL;
         if (init_p && mode_q != MODE_NORMAL) begin
            mode_q  <= MODE_NORMAL;
            class_q <= 3'h0;
         // R24: range check class
         end else if (init_p) begin
            class_q <= (class_q > CLASS_NORM_MAX) ? 3'h0 : class_q;
         end else if (exec_p && dg_q != DG_ISSUE && dg_q != DG_WAIT) begin
            mode_q  <= msw_s;
            class_q <= csw_s;
         end
      end
   end
   // step list for the exerciser classes
   function automatic logic [3:0] step_at(input logic [2:0] c, input logic [3:0] i);
      logic [3:0] j;
      logic [3:0] k;
      begin
         step_at = T_END;
         k = 4'hf;
         // R18: format slot skipped outside classes 0, 3 and 4
         j = (c == 3'h0 || c == 3'h3 || c == 3'h4 || i == 4'h0) ? i : i + 4'h1;
         // R19: fixed disk only after self-test
         if (c == 3'h2)
            k = i - 4'h1;
         // R20: fixed tests follow the floppy list
         else if (c >= 3'h3 && j >= 4'ha)
            k = j - 4'ha;
         // R17: floppy exerciser order
         case ((c == 3'h2 && i != 4'h0) ? 4'hf : j)
            4'h0: step_at = T_SELF;
            4'h1: step_at = T_FMT_SD;
            4'h2: step_at = T_FSCAN;
            4'h3: step_at = T_FBFLY;
            4'h4: step_at = T_FWR;
            4'h5: step_at = T_SET_DD;
            4'h6: step_at = T_FSCAN;
            4'h7: step_at = T_FBFLY;
            4'h8: step_at = T_FWR;
            4'h9: step_at = T_SET_SD;
            default: ;
         endcase
         case (k)
            4'h0: step_at = T_WSCAN;
            4'h1: step_at = T_WBFLY;
            // R22: class 6 skips write/read
            4'h2: step_at = (c == 3'h6) ? T_END : T_WWR;
            default: ;
         endcase
      end
   endfunction
   assign step = step_at(class_q, idx_q);
   logic       single_pass, stop_dg, treq_q;
   logic [3:0] tid_q;
   // R21: classes 4 and 5 run once
   assign single_pass = (class_q == 3'h4) || (class_q == 3'h5);
   assign stop_dg = (init_p && mode_q != MODE_NORMAL) || sw_abort;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dg_q   <= DG_IDLE;
         idx_q  <= 4'h0;
         tid_q  <= T_END;
         treq_q <= 1'b0;
      end else begin
         treq_q <= 1'b0;
         if (stop_dg) begin
            dg_q <= DG_IDLE;
         end else begin
            case (dg_q)
               DG_ISSUE: begin
                  if (step == T_END) begin
                     idx_q <= 4'h0;
                     if (single_pass)
                        dg_q <= DG_DONE;
                  end else begin
                     tid_q  <= step;
                     treq_q <= 1'b1;
                     dg_q   <= DG_WAIT;
                  end
               end
               DG_WAIT: begin
                  if (test_done && test_err)
                     dg_q <= DG_IDLE;
                  else if (test_done) begin
                     idx_q <= idx_q + 4'h1;
                     dg_q  <= DG_ISSUE;
                  end
               end
               default: begin
                  // only mode 2 sequences live here; class 7 is refused
                  if (start_req && msw_s == MODE_EXER && csw_s != 3'h7) begin
                     idx_q <= 4'h0;
                     dg_q  <= DG_ISSUE;
                  end
               end
            endcase
         end
      end
   end
   assign test_req    = treq_q;
   assign test_id     = tid_q;
   assign home_drives = home_q;
   // registered panel outputs
   logic [7:0] shown;
   logic       running;
   logic       shown_drv;
   assign running   = (dg_q == DG_ISSUE) || (dg_q == DG_WAIT);
   assign shown_drv = ev_v_q[recent_q] ? recent_q : ~recent_q;
   always_comb begin
      // R12: latest error code
      if (any_err)
         shown = code_q[shown_drv];
      // R14: test code while running
      else if (running)
         shown = {1'b0, mode_q, 1'b0, class_q};
      else
         shown = CODE_NONE;
   end
   leds_t      leds_q;
   logic [7:0] disp_q;
   logic       blank_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         leds_q  <= '0;
         disp_q  <= CODE_NONE;
         blank_q <= 1'b0;
      end else begin
         // R01: activity and lock
         leds_q.flp_activity  <= head_s;
         leds_q.flp_door_lock <= head_s & lock_s;
         // R05: fault wins; R02: warm-up flash; R03, R04: map read and flicker
         leds_q.fix_ready <= !fault_s &&
                             (warm_done ? btm_ok && flk_q == 16'h0000 : flash_q);
         // R06: floppy protect
         leds_q.flp_wp <= fwps_s | fdwp_s;
         // R07: fixed protect
         leds_q.fix_wp <= xwps_s;
         // R08: flash then steady
         leds_q.fault <= fault_on_q && (flt_q == 20'(FAULT_TKS) || flash_q);
         // R11: shown drive flashes; R15: other steady
         leds_q.flp_err <= ev_v_q[DRV_FLOPPY] && (shown_drv != DRV_FLOPPY || flash_q);
         leds_q.fix_err <= ev_v_q[DRV_FIXED] && (shown_drv != DRV_FIXED || flash_q);
         disp_q  <= shown;
         blank_q <= any_err && !flash_q;
      end
   end
   assign leds         = leds_q;
   assign disp_code    = disp_q;
   assign disp_blank   = blank_q;
   // R02: protect held through warm-up
   assign fix_wp_force = ~warm_done;
   // register reads; unmapped reads give zero
   logic [7:0] rd_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         rd_q <= 8'h00;
      else if (rd && addr == REG_CTRL)
         rd_q <= ctrl_q;
      else if (rd && addr == REG_STATUS)
         rd_q <= {running, dg_q == DG_DONE, ev_v_q, recent_q, class_q};
      else if (rd && addr == REG_ERRS)
         rd_q <= shown;
      else
         rd_q <= 8'h00;
   end
   assign rdata = rd_q;
endmodule
`default_nettype wire

/* File: sim/panel_status_indicator_ctrl_checker.sv */
// assertion checker for the panel indicator block
// bound to the design top; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module panel_status_indicator_ctrl_checker (
   input wire logic                mclk,
   input wire logic                rst_n,
   input wire logic                head_loaded,
   input wire logic                lock_fitted,
   input wire logic                flp_wp_switch,
   input wire logic                flp_disk_wp,
   input wire logic                fix_wp_switch,
   input wire logic                drive_fault,
   input wire logic                fix_access,
   input wire panel_pkg::err_evt_t err_evt,
   input wire panel_pkg::leds_t    leds,
   input wire logic [7:0]          disp_code
);
   import panel_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // five samples cover the pin synchroniser and the output flop
   sequence s_head;
      head_loaded [*5];
   endsequence
   sequence s_lock;
      (head_loaded && lock_fitted) [*5];
   endsequence
   sequence s_err;
      err_evt.valid ##2 1'b1;
   endsequence
   AST_ACTIVITY: assert property (s_head |-> leds.flp_activity)
      else $error("activity led dark with head loaded");
   AST_LOCK: assert property (s_lock |-> leds.flp_door_lock)
      else $error("door not locked with head loaded");
   AST_FLP_WP: assert property ((flp_wp_switch || flp_disk_wp) [*5] |-> leds.flp_wp)
      else $error("floppy protect led dark");
   AST_FIX_WP: assert property (fix_wp_switch [*5] |-> leds.fix_wp)
      else $error("fixed protect led dark");
   AST_FIX_WP_OFF: assert property (!fix_wp_switch [*5] |-> !leds.fix_wp)
      else $error("fixed protect led lit without switch");
   AST_FAULT_RDY: assert property (drive_fault [*5] |-> !leds.fix_ready)
      else $error("ready lit during drive fault");
   AST_FLICKER: assert property (fix_access |-> ##[1:3] !leds.fix_ready)
      else $error("no flicker after access");
   AST_ERR_CODE: assert property (s_err |-> disp_code == $past(err_evt.code, 2))
      else $error("display not showing latest error");
endmodule
bind panel_status_indicator_ctrl panel_status_indicator_ctrl_checker u_chk (
   .mclk(mclk), .rst_n(rst_n), .head_loaded(head_loaded), .lock_fitted(lock_fitted),
   .flp_wp_switch(flp_wp_switch), .flp_disk_wp(flp_disk_wp), .fix_wp_switch(fix_wp_switch),
   .drive_fault(drive_fault), .fix_access(fix_access), .err_evt(err_evt), .leds(leds),
   .disp_code(disp_code)
);
`default_nettype wire

/* File: sim/panel_far_side.sv */
// drive-side model answering exerciser step requests
// answers alternate prompt and slow so both pacings are seen
`timescale 1ns/1ps
`default_nettype none
module panel_far_side (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic test_req,
   output logic     test_done,
   output logic     test_err
);
   logic [3:0] cnt_q;
   logic       slow_q;
   // steps never fail here; no scenario asks for it
   assign test_err = 1'b0;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
         slow_q <= 1'b0;
         test_done <= 1'b0;
      end else begin
         test_done <= (cnt_q == 4'h1);
         if (test_req) begin
            cnt_q <= slow_q ? 4'h6 : 4'h1;
            slow_q <= !slow_q;
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: sim/tb_panel_status_indicator_ctrl.sv */
// self-checking bench for the panel indicator block
// short timer parameters: tick 4 cycles, flash 2, fault and warm-up 20 ticks
`timescale 1ns/1ps
`default_nettype none
module tb_panel_status_indicator_ctrl;
   import panel_pkg::*;
   logic       mclk, rst_n, head_loaded, lock_fitted, flp_wp_switch, flp_disk_wp;
   logic       fix_wp_switch, drive_fault, bus_init, execute_btn, fix_access;
   logic       test_done, test_err, wr, rd, disp_blank, fix_wp_force, home_drives;
   logic       test_req, s0, s1, h;
   logic [2:0] mode_sw, class_sw;
   logic [3:0] addr, test_id;
   logic [7:0] wdata, rdata, disp_code, r;
   err_evt_t   err_evt;
   err_clr_t   err_clr;
   leds_t      leds;
   int         miscompares = 0;
   int         n_checks = 0;
   panel_status_indicator_ctrl #(.TICK_CYCLES(4), .FLASH_TICKS(2), .FLICKER_TICKS(2),
      .FAULT_TKS(20), .WARMUP_TKS(20)) DUT (
      .mclk(mclk), .rst_n(rst_n), .head_loaded(head_loaded), .lock_fitted(lock_fitted),
      .flp_wp_switch(flp_wp_switch), .flp_disk_wp(flp_disk_wp),
      .fix_wp_switch(fix_wp_switch), .drive_fault(drive_fault), .bus_init(bus_init),
      .execute_btn(execute_btn), .mode_sw(mode_sw), .class_sw(class_sw),
      .fix_access(fix_access), .err_evt(err_evt), .err_clr(err_clr),
      .test_done(test_done), .test_err(test_err), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .leds(leds), .disp_code(disp_code), .disp_blank(disp_blank),
      .fix_wp_force(fix_wp_force), .home_drives(home_drives), .test_req(test_req),
      .test_id(test_id));
   panel_far_side u_far (.mclk(mclk), .rst_n(rst_n), .test_req(test_req),
      .test_done(test_done), .test_err(test_err));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // samples one led for n cycles, noting whether it was seen dark and lit
   task automatic watch(input int b, input int n, output logic z, output logic o);
      z = 0;
      o = 0;
      repeat (n) begin
         @(posedge mclk);
         #1;
         if (leds[b] === 1'b0) z = 1;
         if (leds[b] === 1'b1) o = 1;
      end
   endtask
   task automatic err(input logic dv, input logic [7:0] c);
      @(posedge mclk);
      err_evt <= '{1'b1, dv, c};
      @(posedge mclk);
      err_evt <= '0;
   endtask
   task automatic bus_pulse(output logic hp);
      hp = 0;
      for (int k = 0; k < 12; k++) begin
         @(posedge mclk);
         bus_init <= (k < 4);
         #1;
         if (home_drives === 1'b1) hp = 1;
      end
   endtask
   task automatic start(input logic [2:0] m, input logic [2:0] c);
      @(posedge mclk);
      mode_sw <= m;
      class_sw <= c;
      cyc(4);
      execute_btn <= 1'b1;
      cyc(2);
      execute_btn <= 1'b0;
      #1;
   endtask
   task automatic run_class(input logic [2:0] c);
      logic [63:0] seq;
      int n;
      int w;
      logic f, x, s;
      seq = '0;
      f = 0;
      x = 0;
      s = 0;
      start(3'h2, c);
      for (n = 0; n < 16; n++) begin
         w = 0;
         while (test_req !== 1'b1 && w < 100) begin
            @(posedge mclk);
            #1;
            w++;
         end
         if (w == 100) break;
         seq[4*n +: 4] = test_id;
         f |= (test_id === T_FMT_SD);
         x |= (test_id === T_WWR);
         s |= (test_id === T_WSCAN);
         if (n == 0) chk(disp_code, {5'h04, c});
         @(posedge mclk);
         #1;
      end
      rd_reg(REG_STATUS, r);
      if (c == 3'h4 || c == 3'h5) begin
         chk(r[7:6], 2'b01);
         chk(disp_code, CODE_NONE);
      end else begin
         chk(r[7:6], 2'b10);
         wr_reg(REG_CTRL, 8'h0c);
      end
      // format, fixed write/read and fixed scan per class 0..6
      chk({f, x, s}, {|(7'b0011001 & (7'h1 << c)), |(7'b0111100 & (7'h1 << c)),
         |(7'b1111100 & (7'h1 << c))});
      if (c == 3'h0) chk(seq[39:0], 40'h7543654321);
      if (c == 3'h1) chk(seq[35:0], 36'h754365431);
      if (c == 3'h2) chk(seq[31:0], 32'ha981a981);
      $display("test class %0d done", c);
   endtask
   initial begin
      #1000000;
      miscompares++;
      close_out;
   end
   initial begin
      {rst_n, head_loaded, lock_fitted, flp_wp_switch, flp_disk_wp, fix_wp_switch} = '0;
      {drive_fault, bus_init, execute_btn, fix_access, wr, rd} = '0;
      {mode_sw, class_sw, addr, wdata} = '0;
      err_evt = '0;
      err_clr = '0;
      cyc(20);
      rst_n <= 1'b1;
      cyc(2);
      #1 chk(fix_wp_force, 1'b1);
      wr_reg(REG_CTRL, 8'h08);
      rd_reg(REG_CTRL, r);
      chk(r, 8'h08);
      rd_reg(4'hc, r);
      chk(r, 8'h00);
      watch(5, 30, s0, s1);
      chk({s0, s1}, 2'b11);
      @(posedge mclk);
      {head_loaded, lock_fitted, flp_disk_wp, fix_wp_switch} <= 4'hf;
      cyc(6);
      #1 chk({leds.flp_activity, leds.flp_door_lock, leds.flp_wp, leds.fix_wp}, 4'hf);
      @(posedge mclk);
      {lock_fitted, flp_disk_wp, fix_wp_switch, flp_wp_switch} <= 4'h1;
      cyc(6);
      #1 chk({leds.flp_activity, leds.flp_door_lock, leds.flp_wp, leds.fix_wp}, 4'ha);
      $display("test pins done");
      cyc(70);
      #1 chk(fix_wp_force, 1'b0);
      watch(5, 20, s0, s1);
      chk({s0, s1}, 2'b01);
      @(posedge mclk);
      fix_access <= 1'b1;
      @(posedge mclk);
      fix_access <= 1'b0;
      cyc(2);
      #1 chk(leds.fix_ready, 1'b0);
      cyc(20);
      drive_fault <= 1'b1;
      #1 chk(leds.fix_ready, 1'b1);
      cyc(25);
      drive_fault <= 1'b0;
      #1 chk(leds.fix_ready, 1'b0);
      cyc(8);
      #1 chk(leds.fix_ready, 1'b1);
      $display("test ready done");
      err(DRV_FLOPPY, 8'h21);
      cyc(3);
      #1 chk(disp_code, 8'h21);
      watch(2, 50, s0, s1);
      chk({s0, s1}, 2'b11);
      err(DRV_FIXED, 8'h35);
      cyc(30);
      watch(2, 25, s0, s1);
      chk({s0, s1}, 2'b11);
      cyc(50);
      watch(2, 20, s0, s1);
      chk({s0, s1}, 2'b01);
      watch(1, 20, s0, s1);
      chk({s0, s1}, 2'b01);
      watch(0, 20, s0, s1);
      chk({s0, s1, disp_code}, {2'b11, 8'h35});
      rd_reg(REG_STATUS, r);
      chk(r[5:3], 3'b111);
      @(posedge mclk);
      err_clr <= '{1'b1, DRV_FIXED};
      @(posedge mclk);
      err_clr <= '0;
      cyc(3);
      #1 chk(disp_code, 8'h21);
      watch(1, 20, s0, s1);
      chk({s0, s1}, 2'b11);
      bus_pulse(h);
      chk({h, leds.fault, disp_code}, 10'h000);
      rd_reg(REG_STATUS, r);
      chk(r[5:4], 2'b00);
      $display("test errors done");
      for (int c = 0; c < 7; c++) run_class(3'(c));
      start(3'h2, 3'h0);
      cyc(10);
      bus_pulse(h);
      rd_reg(REG_STATUS, r);
      chk({h, r[7], r[2:0]}, 5'h10);
      start(3'h0, 3'h5);
      rd_reg(REG_STATUS, r);
      chk(r[2:0], 3'h5);
      bus_pulse(h);
      rd_reg(REG_STATUS, r);
      chk({h, r[2:0]}, 4'h0);
      $display("test init done");
      close_out;
   end
endmodule
`default_nettype wire
